//--- nfoc_feature_ctrl.v
// Feature parameter and OTP access control inside the flash device
// What this block does
// - Set-feature opcode, address, then P1..P4 replace power-on defaults.
// - After set-feature opcode, stay in set-feature mode until P4 or next command.
// - Status read during set-feature reports ready once parameters applied.
// - Get-feature opcode and address, then P1..P4 read from data bus.
// - After get-feature opcode, stay in get-feature mode until next command.
// - P1 01h, zero P2..P4, at address 90h enters OTP operation mode.
// - Zero P1 at address 90h leaves OTP operation or protection mode.
// - Array mode and recovery read parameters clear on power cycle.
// - In OTP mode page read and program target the OTP region.
// - OTP pages are page addresses 02h to 1Fh only.
// - OTP mode allows random data out but refuses cache read.
// - OTP mode accepts random data input then program confirm.
// - At most eight partial programs per OTP page.
// - OTP region never erased; programming only clears bits.
// - Once OTP protection set, all OTP programs are refused.
// - Ready or busy shown on busy line and in status byte.
// - Scrambler, when enabled, also covers OTP region data.
// - Protection parameter resets to 38h on power cycle.
// - Protection writes ignored unless protect strap was high.
// - After solid lock set, protection bits frozen until power cycle.
// - Scrambler enable and coverage bits are one-time and persistent.
// - Scrambler program-enable flag is volatile.
// - Address 89h selects one of five recovery read modes.
// - P1 03h at 90h then program with address 00h sets OTP protection.
`timescale 1ns/1ns
`include "nfoc_defs.vh"
module nfoc_feature_ctrl #(
   parameter BUSY_CYCLES = `NFOC_TFEAT_CYC
) (
   input  wire       core_clk,
   input  wire       srst,
   input  wire       cmdStrobe,
   input  wire       addrStrobe,
   input  wire       dataInStrobe,
   input  wire       dataOutStrobe,
   input  wire [7:0] busIn,
   input  wire       protect_strap_pin,
   input  wire       writeProtectN,
   input  wire       arrayDone,
   input  wire [2:0] scrambleNvIn,
   output reg  [7:0] busOut,
   output reg        busOutEn,
   output reg        readyBusyN,
   output reg        otpSelect,
   output reg        otpProtected,
   output reg  [4:0] otpPage,
   output reg        arrayReadStart,
   output reg        arrayProgStart,
   output reg        progRefused,
   output reg        scrambleActive,
   output reg        scramble_coverage_select,
   output reg        scrambleNvWrite,
   output reg  [2:0] recoveryMode,
   output reg  [5:0] protectSetting
);
   // ------------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------------
   localparam ST_IDLE    = 4'd0;
   localparam ST_SF_ADDR = 4'd1;
   localparam ST_SF_DATA = 4'd2;
   localparam ST_GF_ADDR = 4'd3;
   localparam ST_GF_DATA = 4'd4;
   localparam ST_STATUS  = 4'd5;
   localparam ST_RD_ADDR = 4'd6;
   localparam ST_RD_DATA = 4'd7;
   localparam ST_PG_ADDR = 4'd8;
   localparam ST_PG_DATA = 4'd9;
   localparam ST_OTHER   = 4'd10;

   reg [3:0]  state;
   reg [3:0]  statusReturn;
   reg [7:0]  featAddr;
   reg [1:0]  byteIdx;
   reg [7:0]  paramP1;
   reg        paramBad;
   reg [7:0]  array_operation_mode;
   reg [7:0]  block_protection_setting;
   reg [7:0]  scrambler_configuration;
   reg [7:0]  recoveryParam;
   reg        protectEnabled;
   reg        strapCaught;
   reg        scrambleLocked;
   reg [2:0]  addrCount;
   reg [7:0]  pageAddr;
   reg [15:0] busyCount;
   reg        progPending;
   reg        progDirty;

   wire       otpMode  = (array_operation_mode == `NFOC_MODE_OTP);
   wire       protMode = (array_operation_mode == `NFOC_MODE_OTPPROT);
   wire       busy     = (busyCount != 16'h0000) | progPending;

   wire [3:0] nopCount;
   reg        nopWr;
   reg  [3:0] nopData;

   // Page address inside the OTP window
   function inOtpWindow;
      input [7:0] pa;
      begin
         inOtpWindow = (pa >= `NFOC_OTP_FIRST) && (pa <= `NFOC_OTP_LAST);
      end
   endfunction

   // Read back of one parameter byte
   function [7:0] featByte;
      input [7:0] fa;
      input [1:0] idx;
      input [7:0] am;
      input [7:0] bp;
      input [7:0] cf;
      input [7:0] rc;
      begin
         featByte = 8'h00;
         if (idx == 2'd0) begin
            case (fa)
               `NFOC_FA_ARRAYMODE: featByte = am;
               `NFOC_FA_PROTECT:   featByte = bp & `NFOC_PR_MASK;
               `NFOC_FA_CONFIG:    featByte = cf;
               `NFOC_FA_RECOVERY:  featByte = rc;
               default:            featByte = 8'h00;
            endcase
         end
      end
   endfunction

   nfoc_otp_mem #(
      .AW (5),
      .DW (4)
   ) uNopMem (
      .core_clk (core_clk),
      .srst     (srst),
      .wrEn     (nopWr),
      .wrAddr   (pageAddr[4:0]),
      .wrData   (nopData),
      .rdAddr   (pageAddr[4:0]),
      .rdData   (nopCount)
   );

   // ------------------------------------------------------------------
   // Command sequencer and feature registers
   // ------------------------------------------------------------------
   always @(posedge core_clk) begin
      if (srst) begin
         state                    <= ST_IDLE;
         statusReturn             <= ST_IDLE;
         featAddr                 <= 8'h00;
         byteIdx                  <= 2'd0;
         paramP1                  <= 8'h00;
         paramBad                 <= 1'b0;
         array_operation_mode     <= `NFOC_RST_ARRAYMODE;
         recoveryParam            <= `NFOC_RST_RECOVERY;
         block_protection_setting <= `NFOC_RST_PROTECT;
         scrambler_configuration  <= `NFOC_RST_CONFIG;
         protectEnabled           <= 1'b0;
         strapCaught              <= 1'b0;
         scrambleLocked           <= 1'b0;
         addrCount                <= 3'd0;
         pageAddr                 <= 8'h00;
         busyCount                <= 16'h0000;
         progPending              <= 1'b0;
         progDirty                <= 1'b0;
         nopWr                    <= 1'b0;
         nopData                  <= 4'h0;
         busOut                   <= 8'h00;
         busOutEn                 <= 1'b0;
         readyBusyN               <= 1'b1;
         otpSelect                <= 1'b0;
         otpProtected             <= 1'b0;
         otpPage                  <= 5'h00;
         arrayReadStart           <= 1'b0;
         arrayProgStart           <= 1'b0;
         progRefused              <= 1'b0;
         scrambleActive           <= 1'b0;
         scramble_coverage_select <= 1'b0;
         scrambleNvWrite          <= 1'b0;
         recoveryMode             <= 3'd0;
         protectSetting           <= 6'h38;
      end else begin
         arrayReadStart  <= 1'b0;
         arrayProgStart  <= 1'b0;
         progRefused     <= 1'b0;
         scrambleNvWrite <= 1'b0;
         nopWr           <= 1'b0;
         busOutEn        <= 1'b0;
         // Strap caught once after release
         if (!strapCaught) begin
            strapCaught    <= 1'b1;
            protectEnabled <= protect_strap_pin;
         end
         if (!scrambleLocked && scrambleNvIn[1]) begin
            scrambler_configuration[`NFOC_CF_SCREN]  <= 1'b1;
            scrambler_configuration[`NFOC_CF_COVSEL] <= scrambleNvIn[2];
            scrambleLocked                           <= 1'b1;
         end
         if (busyCount != 16'h0000) begin
            busyCount <= busyCount - 16'h0001;
         end
         if (progPending && arrayDone) begin
            progPending <= 1'b0;
         end
         if (cmdStrobe) begin
            // Any valid opcode ends the feature modes
            addrCount <= 3'd0;
            byteIdx   <= 2'd0;
            case (busIn)
               `NFOC_OP_SETFEAT: state <= ST_SF_ADDR;
               `NFOC_OP_GETFEAT: state <= ST_GF_ADDR;
               `NFOC_OP_STATUS: begin
                  statusReturn <= (state == ST_GF_DATA) ? ST_GF_DATA : ST_IDLE;
                  state        <= ST_STATUS;
               end
               `NFOC_OP_READ: begin
                  // Read opcode resumes get-feature data after status
                  if (state == ST_STATUS && statusReturn == ST_GF_DATA) begin
                     state <= ST_GF_DATA;
                  end else begin
                     state <= ST_RD_ADDR;
                  end
               end
               `NFOC_OP_READCONF: begin
                  otpSelect <= otpMode && inOtpWindow(pageAddr);
                  otpPage   <= pageAddr[4:0];
                  scrambleActive <= scrambler_configuration[`NFOC_CF_SCREN];
                  arrayReadStart <= 1'b1;
                  state     <= ST_RD_DATA;
               end
               `NFOC_OP_RNDOUT, `NFOC_OP_RNDOUTCONF: state <= ST_RD_DATA;
               `NFOC_OP_CACHESEQ, `NFOC_OP_CACHEEND: begin
                  if (otpMode || protMode) begin
                     progRefused <= 1'b1;
                     state       <= ST_IDLE;
                  end else begin
                     arrayReadStart <= 1'b1;
                     state          <= ST_RD_DATA;
                  end
               end
               `NFOC_OP_PROG: begin
                  progDirty <= 1'b0;
                  state     <= ST_PG_ADDR;
               end
               `NFOC_OP_RNDIN: state <= ST_PG_ADDR;
               `NFOC_OP_PROGCONF: begin
                  state <= ST_IDLE;
                  if (protMode && !otpProtected) begin
                     otpProtected <= 1'b1;
                     busyCount    <= BUSY_CYCLES[15:0];
                  end else if (otpMode) begin
                     if (otpProtected || !inOtpWindow(pageAddr)
                         || nopCount >= `NFOC_OTP_NOP_MAX) begin
                        progRefused <= 1'b1;
                     end else begin
                        // Array applies AND of old and new data
                        otpSelect      <= 1'b1;
                        otpPage        <= pageAddr[4:0];
                        scrambleActive <= scrambler_configuration[`NFOC_CF_SCREN];
                        arrayProgStart <= 1'b1;
                        progPending    <= 1'b1;
                        nopWr          <= 1'b1;
                        nopData        <= nopCount + 4'h1;
                     end
                  end else if (!protMode) begin
                     otpSelect      <= 1'b0;
                     scrambleActive <= scrambler_configuration[`NFOC_CF_SCREN];
                     arrayProgStart <= 1'b1;
                     progPending    <= 1'b1;
                  end else begin
                     progRefused <= 1'b1;
                  end
               end
               default: state <= ST_OTHER;
            endcase
         end else if (addrStrobe) begin
            case (state)
               ST_SF_ADDR: begin
                  featAddr <= busIn;
                  state    <= ST_SF_DATA;
               end
               ST_GF_ADDR: begin
                  featAddr <= busIn;
                  busyCount <= BUSY_CYCLES[15:0];
                  state    <= ST_GF_DATA;
               end
               ST_RD_ADDR, ST_PG_ADDR: begin
                  // Third address cycle carries the page address
                  if (addrCount == 3'd2) begin
                     pageAddr <= busIn;
                  end
                  if (addrCount != 3'd7) begin
                     addrCount <= addrCount + 3'd1;
                  end
               end
               default: state <= state;
            endcase
         end else if (dataInStrobe) begin
            if (state == ST_SF_DATA) begin
               if (byteIdx == 2'd0) begin
                  paramP1  <= busIn;
                  paramBad <= 1'b0;
               end else if (busIn != 8'h00) begin
                  paramBad <= 1'b1;
               end
               byteIdx <= byteIdx + 2'd1;
               if (byteIdx == 2'd3) begin
                  busyCount <= BUSY_CYCLES[15:0];
                  state     <= ST_IDLE;
                  case (featAddr)
                     `NFOC_FA_ARRAYMODE: begin
                        if (paramP1 == `NFOC_MODE_NORMAL) begin
                           array_operation_mode <= `NFOC_MODE_NORMAL;
                        end else if (!paramBad && busIn == 8'h00 &&
                                     (paramP1 == `NFOC_MODE_OTP ||
                                      paramP1 == `NFOC_MODE_OTPPROT)) begin
                           array_operation_mode <= paramP1;
                        end
                     end
                     `NFOC_FA_PROTECT: begin
                        if (protectEnabled && writeProtectN &&
                            !block_protection_setting[`NFOC_PR_SOLID]) begin
                           block_protection_setting <= paramP1 & `NFOC_PR_MASK;
                        end
                     end
                     `NFOC_FA_CONFIG: begin
                        scrambler_configuration[`NFOC_CF_PGMEN] <= paramP1[`NFOC_CF_PGMEN];
                        if (scrambler_configuration[`NFOC_CF_PGMEN] && !scrambleLocked &&
                            paramP1[`NFOC_CF_SCREN]) begin
                           scrambler_configuration[`NFOC_CF_SCREN]  <= 1'b1;
                           scrambler_configuration[`NFOC_CF_COVSEL] <=
                              paramP1[`NFOC_CF_COVSEL];
                           scrambleLocked  <= 1'b1;
                           scrambleNvWrite <= 1'b1;
                        end
                     end
                     `NFOC_FA_RECOVERY: begin
                        if (paramP1 <= `NFOC_RECOVERY_MAX) begin
                           recoveryParam <= paramP1;
                        end
                     end
                     default: state <= ST_IDLE;
                  endcase
               end
            end else if (state == ST_PG_ADDR || state == ST_PG_DATA) begin
               progDirty <= 1'b1;
               state     <= ST_PG_DATA;
            end
         end else if (dataOutStrobe) begin
            busOutEn <= 1'b1;
            if (state == ST_STATUS) begin
               busOut <= {writeProtectN, ~busy, 5'b00000, 1'b0};
            end else if (state == ST_GF_DATA) begin
               busOut <= featByte(featAddr, byteIdx, array_operation_mode,
                                  block_protection_setting, scrambler_configuration,
                                  recoveryParam);
               byteIdx <= byteIdx + 2'd1;
            end else begin
               busOut <= 8'hFF;
            end
         end
         readyBusyN     <= ~busy;
         recoveryMode   <= recoveryParam[2:0];
         protectSetting <= block_protection_setting[5:0];
         scramble_coverage_select <= scrambler_configuration[`NFOC_CF_COVSEL];
         if (!(otpMode || protMode)) begin
            otpSelect <= 1'b0;
         end
      end
   end
endmodule

//--- nfoc_defs.vh
// Constants for the feature parameter and OTP control block
`ifndef NFOC_DEFS_VH
`define NFOC_DEFS_VH
// Opcodes
`define NFOC_OP_SETFEAT    8'hEF
`define NFOC_OP_GETFEAT    8'hEE
`define NFOC_OP_STATUS     8'h70
`define NFOC_OP_READ       8'h00
`define NFOC_OP_READCONF   8'h30
`define NFOC_OP_PROG       8'h80
`define NFOC_OP_PROGCONF   8'h10
`define NFOC_OP_RNDIN      8'h85
`define NFOC_OP_RNDOUT     8'h05
`define NFOC_OP_RNDOUTCONF 8'hE0
`define NFOC_OP_CACHESEQ   8'h31
`define NFOC_OP_CACHEEND   8'h3F
`define NFOC_OP_RESET      8'hFF
// Feature addresses
`define NFOC_FA_RECOVERY   8'h89
`define NFOC_FA_ARRAYMODE  8'h90
`define NFOC_FA_PROTECT    8'hA0
`define NFOC_FA_CONFIG     8'hB0
// Reset values
`define NFOC_RST_ARRAYMODE 8'h00
`define NFOC_RST_PROTECT   8'h38
`define NFOC_RST_CONFIG    8'h00
`define NFOC_RST_RECOVERY  8'h00
// Array mode codes and recovery parameter limit
`define NFOC_MODE_NORMAL   8'h00
`define NFOC_MODE_OTP      8'h01
`define NFOC_MODE_OTPPROT  8'h03
`define NFOC_RECOVERY_MAX  8'h05
// Protection P1 field positions
`define NFOC_PR_SOLID      0
`define NFOC_PR_COMPL      1
`define NFOC_PR_INVERT     2
`define NFOC_PR_RANGE_LO   3
`define NFOC_PR_RANGE_HI   5
`define NFOC_PR_MASK       8'h3F
// Configuration P1 field positions
`define NFOC_CF_PGMEN      0
`define NFOC_CF_SCREN      1
`define NFOC_CF_COVSEL     2
// OTP region
`define NFOC_OTP_FIRST     8'h02
`define NFOC_OTP_LAST      8'h1F
`define NFOC_OTP_NOP_MAX   4'h8
// Status bits
`define NFOC_ST_FAIL       0
`define NFOC_ST_READY      6
`define NFOC_ST_WPN        7
// Busy time, ns, and cycles at 100 ns clock
`define NFOC_CLK_NS        100
`define NFOC_TFEAT_NS      1000
`define NFOC_TFEAT_CYC     ((`NFOC_TFEAT_NS + `NFOC_CLK_NS - 1) / `NFOC_CLK_NS)
`endif

//--- nfoc_otp_mem.v
// Per-page partial program counters for the OTP region
`timescale 1ns/1ns
module nfoc_otp_mem #(
   parameter AW = 5,
   parameter DW = 4
) (
   input  wire          core_clk,
   input  wire          srst,
   input  wire          wrEn,
   input  wire [AW-1:0] wrAddr,
   input  wire [DW-1:0] wrData,
   input  wire [AW-1:0] rdAddr,
   output reg  [DW-1:0] rdData
);
   reg [DW-1:0] mem [0:(1<<AW)-1];
   integer i;
   always @(posedge core_clk) begin
      if (srst) begin
         for (i = 0; i < (1<<AW); i = i + 1) begin
            mem[i] <= {DW{1'b0}};
         end
         rdData <= {DW{1'b0}};
      end else begin
         if (wrEn) begin
            mem[wrAddr] <= wrData;
         end
         rdData <= mem[rdAddr];
      end
   end
endmodule

//--- nfoc_feature_ctrl_sva.sv
// Port assertions for the feature parameter and OTP control block
`timescale 1ns/1ns
module nfoc_feature_ctrl_sva #(
   parameter BUSY_CYCLES = 10
) (
   input logic       core_clk,
   input logic       srst,
   input logic       cmdStrobe,
   input logic       dataOutStrobe,
   input logic [7:0] busIn,
   input logic       busOutEn,
   input logic       readyBusyN,
   input logic       otpSelect,
   input logic       otpProtected,
   input logic       progRefused,
   input logic [2:0] recoveryMode,
   input logic [5:0] protectSetting
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   logic [7:0] lowCnt;
   // Length of the current busy stretch
   always @(posedge core_clk) begin
      if (srst || readyBusyN) lowCnt <= 8'h00;
      else if (lowCnt != 8'hFF) lowCnt <= lowCnt + 8'h01;
   end
   a_read_answer: assert property (dataOutStrobe |=> busOutEn)
      else $error("no answer byte after a data out strobe");
   a_answer_cause: assert property (busOutEn |-> $past(dataOutStrobe))
      else $error("answer byte without a data out strobe");
   a_reset_values: assert property ($fell(srst) |-> protectSetting == 6'h38 &&
      recoveryMode == 3'h0 && !otpSelect && !otpProtected)
      else $error("wrong parameter values after reset");
   a_protect_sticky: assert property ($past(otpProtected) |-> otpProtected)
      else $error("OTP protection dropped");
   a_solid_freeze: assert property ($past(protectSetting[0]) |-> $stable(protectSetting))
      else $error("protection bits changed under solid lock");
   a_cache_refused: assert property (cmdStrobe && otpSelect &&
      (busIn == 8'h31 || busIn == 8'h3F) |=> progRefused)
      else $error("cache opcode not refused in OTP mode");
   a_busy_bound: assert property (lowCnt <= BUSY_CYCLES + 16)
      else $error("busy held too long");
   a_recovery_max: assert property (recoveryMode <= 3'h5)
      else $error("recovery mode out of range");
   a_refuse_pulse: assert property (progRefused |=> !progRefused)
      else $error("refusal longer than one cycle");
endmodule

bind nfoc_feature_ctrl nfoc_feature_ctrl_sva #(.BUSY_CYCLES(BUSY_CYCLES)) uSva (
   .core_clk(core_clk), .srst(srst), .cmdStrobe(cmdStrobe), .dataOutStrobe(dataOutStrobe),
   .busIn(busIn), .busOutEn(busOutEn), .readyBusyN(readyBusyN), .otpSelect(otpSelect),
   .otpProtected(otpProtected), .progRefused(progRefused), .recoveryMode(recoveryMode),
   .protectSetting(protectSetting));

//--- nfoc_host_model.sv
// Flash controller model driving command, address and data cycles
`timescale 1ns/1ns
`include "nfoc_defs.vh"
module nfoc_host_model (
   input  logic       core_clk,
   input  logic [7:0] busOut,
   input  logic       arrayReadStart,
   input  logic       arrayProgStart,
   output logic       cmdStrobe,
   output logic       addrStrobe,
   output logic       dataInStrobe,
   output logic       dataOutStrobe,
   output logic [7:0] busIn,
   output logic       arrayDone
);
   logic [3:0] stb = 4'h0;
   logic [2:0] doneCnt = 3'h0;
   assign {dataOutStrobe, dataInStrobe, addrStrobe, cmdStrobe} = stb;
   initial busIn = 8'h00;
   initial arrayDone = 1'b0;
   // Array stand-in ends every started access four cycles later
   always @(posedge core_clk) begin
      arrayDone <= (doneCnt == 3'h1);
      if (arrayReadStart || arrayProgStart) doneCnt <= 3'h4;
      else if (doneCnt != 3'h0) doneCnt <= doneCnt - 3'h1;
   end
   task automatic cycle(input int k, input logic [7:0] v);
      @(posedge core_clk);
      #1;
      busIn = v;
      stb = 4'h1 << k;
      @(posedge core_clk);
      #1;
      stb = 4'h0;
      busIn = ~v; // Released bus shows no stale byte
   endtask
   task automatic setFeature(input logic [7:0] fa, input logic [7:0] p1);
      cycle(0, `NFOC_OP_SETFEAT);
      cycle(1, fa);
      cycle(2, p1);
      repeat (3) cycle(2, 8'h00);
   endtask
   task automatic readByte(output logic [7:0] v);
      cycle(3, 8'h00);
      v = busOut;
   endtask
   task automatic pageOp(input logic [7:0] op, input logic [7:0] pg, input logic [7:0] conf,
                         input logic rnd);
      cycle(0, op);
      repeat (2) cycle(1, 8'h00);
      cycle(1, pg);
      cycle(1, 8'h00);
      if (op != `NFOC_OP_READ) cycle(2, 8'h5A);
      if (rnd) begin
         cycle(0, `NFOC_OP_RNDIN);
         repeat (2) cycle(1, 8'h10);
         cycle(2, 8'hA5);
      end
      cycle(0, conf);
   endtask
endmodule

//--- nfoc_feature_ctrl_tb.sv
// Self-checking bench for the feature parameter and OTP control block
`timescale 1ns/1ns
`include "nfoc_defs.vh"
module nfoc_feature_ctrl_tb;
   logic       core_clk;
   logic       srst = 1'b1;
   logic       strap = 1'b1;
   logic       writeProtectN = 1'b1;
   logic [2:0] scrambleNvIn = 3'h0;
   logic [7:0] rd;
   int         errCount = 0, totalChecks = 0, cycles = 0, p0;
   int         progN = 0, refN = 0, rdN = 0, nvwN = 0;
   wire        cmdStrobe, addrStrobe, dataInStrobe, dataOutStrobe, arrayDone, busOutEn;
   wire        readyBusyN, otpSelect, otpProtected, arrayReadStart, arrayProgStart;
   wire        progRefused, scrambleActive, covSel, scrambleNvWrite;
   wire [7:0]  busIn, busOut;
   wire [4:0]  otpPage;
   wire [2:0]  recoveryMode;
   wire [5:0]  protectSetting;
   nfoc_feature_ctrl #(.BUSY_CYCLES(2)) DUT (
      .core_clk(core_clk), .srst(srst), .cmdStrobe(cmdStrobe), .addrStrobe(addrStrobe),
      .dataInStrobe(dataInStrobe), .dataOutStrobe(dataOutStrobe), .busIn(busIn),
      .protect_strap_pin(strap), .writeProtectN(writeProtectN), .arrayDone(arrayDone),
      .scrambleNvIn(scrambleNvIn), .busOut(busOut), .busOutEn(busOutEn),
      .readyBusyN(readyBusyN), .otpSelect(otpSelect), .otpProtected(otpProtected),
      .otpPage(otpPage), .arrayReadStart(arrayReadStart), .arrayProgStart(arrayProgStart),
      .progRefused(progRefused), .scrambleActive(scrambleActive),
      .scramble_coverage_select(covSel), .scrambleNvWrite(scrambleNvWrite),
      .recoveryMode(recoveryMode), .protectSetting(protectSetting));
   nfoc_host_model host (
      .core_clk(core_clk), .busOut(busOut), .arrayReadStart(arrayReadStart),
      .arrayProgStart(arrayProgStart), .cmdStrobe(cmdStrobe), .addrStrobe(addrStrobe),
      .dataInStrobe(dataInStrobe), .dataOutStrobe(dataOutStrobe), .busIn(busIn),
      .arrayDone(arrayDone));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic reportAndStop;
      if (errCount == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Pulse tallies and hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (arrayProgStart === 1'b1) progN++;
      if (arrayReadStart === 1'b1) rdN++;
      if (progRefused === 1'b1) refN++;
      if (scrambleNvWrite === 1'b1) nvwN++;
      if (cycles == 20000) begin
         errCount++;
         reportAndStop();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         errCount++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic waitReady;
      int n;
      n = 0;
      repeat (2) @(posedge core_clk);
      #1;
      while (readyBusyN !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk({7'h00, readyBusyN}, 8'h01);
   endtask
   task automatic doReset(input logic pt, input logic [2:0] nv);
      srst = 1'b1;
      strap = pt;
      scrambleNvIn = nv;
      repeat (16) @(posedge core_clk);
      #1;
      srst = 1'b0;
   endtask
   task automatic setF(input logic [7:0] fa, input logic [7:0] p1);
      host.setFeature(fa, p1);
      waitReady();
   endtask
   task automatic chkF(input logic [7:0] fa, input logic [7:0] exp);
      host.cycle(0, `NFOC_OP_GETFEAT);
      host.cycle(1, fa);
      waitReady();
      host.readByte(rd);
      chk(rd, exp);
   endtask
   task automatic stat(input logic [7:0] exp);
      host.cycle(0, `NFOC_OP_STATUS);
      host.readByte(rd);
      chk(rd, exp);
   endtask
   task automatic prog(input logic [7:0] pg, input logic rnd, input logic [7:0] exRef);
      int r0;
      r0 = refN;
      host.pageOp(`NFOC_OP_PROG, pg, `NFOC_OP_PROGCONF, rnd);
      waitReady();
      chk(8'(refN - r0), exRef);
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      #1;
      srst = 1'b0;
      chkF(`NFOC_FA_ARRAYMODE, 8'h00);
      chkF(`NFOC_FA_RECOVERY, 8'h00);
      chkF(`NFOC_FA_CONFIG, 8'h00);
      chkF(`NFOC_FA_PROTECT, 8'h38);
      stat(8'hC0);
      host.cycle(0, `NFOC_OP_READ);
      host.readByte(rd);
      chk(rd, 8'h38);
      for (int m = 1; m <= 5; m++) begin
         setF(`NFOC_FA_RECOVERY, 8'(m));
         chkF(`NFOC_FA_RECOVERY, 8'(m));
      end
      setF(`NFOC_FA_RECOVERY, 8'h06);
      chk({5'h00, recoveryMode}, 8'h05);
      setF(`NFOC_FA_PROTECT, 8'h14);
      chk({2'h0, protectSetting}, 8'h14);
      writeProtectN = 1'b0;
      stat(8'h40);
      setF(`NFOC_FA_PROTECT, 8'h20);
      writeProtectN = 1'b1;
      chkF(`NFOC_FA_PROTECT, 8'h14);
      setF(`NFOC_FA_PROTECT, 8'h15);
      setF(`NFOC_FA_PROTECT, 8'h38);
      chkF(`NFOC_FA_PROTECT, 8'h15);
      doReset(1'b0, 3'h0);
      setF(`NFOC_FA_PROTECT, 8'h00);
      chkF(`NFOC_FA_PROTECT, 8'h38);
      doReset(1'b1, 3'h0);
      setF(`NFOC_FA_ARRAYMODE, `NFOC_MODE_OTP);
      chkF(`NFOC_FA_ARRAYMODE, 8'h01);
      p0 = progN;
      for (int i = 0; i < 8; i++) prog(8'h05, i[0], 8'h00);
      chk({2'h0, otpSelect, otpPage}, 8'h25);
      chk(8'(progN - p0), 8'h08);
      prog(8'h05, 1'b0, 8'h01);
      prog(8'h01, 1'b0, 8'h01);
      prog(8'h1F, 1'b0, 8'h00);
      prog(8'h20, 1'b0, 8'h01);
      p0 = rdN;
      host.pageOp(`NFOC_OP_READ, 8'h02, `NFOC_OP_READCONF, 1'b0);
      waitReady();
      chk(8'(rdN - p0), 8'h01);
      stat(8'hC0);
      p0 = refN;
      host.cycle(0, `NFOC_OP_RNDOUT);
      repeat (2) host.cycle(1, 8'h00);
      host.cycle(0, `NFOC_OP_RNDOUTCONF);
      host.cycle(0, `NFOC_OP_CACHESEQ);
      host.cycle(0, `NFOC_OP_CACHEEND);
      waitReady();
      chk(8'(refN - p0), 8'h02);
      setF(`NFOC_FA_ARRAYMODE, `NFOC_MODE_OTPPROT);
      prog(8'h00, 1'b0, 8'h00);
      chk({7'h00, otpProtected}, 8'h01);
      setF(`NFOC_FA_ARRAYMODE, `NFOC_MODE_OTP);
      prog(8'h02, 1'b0, 8'h01);
      setF(`NFOC_FA_ARRAYMODE, `NFOC_MODE_NORMAL);
      chk({6'h00, otpProtected, otpSelect}, 8'h02);
      setF(`NFOC_FA_CONFIG, 8'h01);
      chkF(`NFOC_FA_CONFIG, 8'h01);
      p0 = nvwN;
      setF(`NFOC_FA_CONFIG, 8'h07);
      chk(8'(nvwN - p0), 8'h01);
      doReset(1'b1, 3'h6);
      chkF(`NFOC_FA_CONFIG, 8'h06);
      host.pageOp(`NFOC_OP_READ, 8'h02, `NFOC_OP_READCONF, 1'b0);
      chk({6'h00, scrambleActive, covSel}, 8'h03);
      reportAndStop();
   end
endmodule
